// *** shared/icg_pkg.sv ***
package icg_pkg;
  // ************************************************************
  // Host I/O port addresses
  // ************************************************************
  localparam logic [15:0] ICG_INDEX_PORT_ADDR = 16'h002e;
  localparam logic [15:0] ICG_DATA_PORT_ADDR  = 16'h002f;

  // ************************************************************
  // Configuration indices and key values
  // ************************************************************
  localparam logic [7:0] ICG_IDX_LDN       = 8'h07;
  localparam logic [7:0] ICG_IDX_DIRECTION = 8'hf0;
  localparam logic [7:0] ICG_IDX_PIN_DATA  = 8'hf1;
  localparam logic [7:0] ICG_IDX_INVERT    = 8'hf2;
  localparam logic [7:0] ICG_KEY_ENTER     = 8'h87;
  localparam logic [7:0] ICG_KEY_EXIT      = 8'haa;
  localparam logic [7:0] ICG_GPIO_LDN      = 8'h09;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] ICG_DIRECTION_RST = 8'hff;
  localparam logic [7:0] ICG_PIN_DATA_RST  = 8'h00;
  localparam logic [7:0] ICG_INVERT_RST    = 8'h00;
  localparam logic [7:0] ICG_INDEX_RST     = 8'h00;
  localparam logic [7:0] ICG_LDN_RST       = 8'h00;
  localparam logic [7:0] ICG_IDLE_READ     = 8'hff;

  typedef enum logic [1:0] {
    ICG_LOCKED,
    ICG_KEY_HALF,
    ICG_UNLOCKED
  } icg_mode_e;
endpackage

// *** hw/icg_gpio_port.sv ***
// Notes on behaviour
// - Index port at 2Eh selects config register.
// - Data port at 2Fh accesses selected register.
// - Two successive 87h index writes unlock.
// - Index write of AAh locks again.
// - Index 07h holds latched logical device number.
// - GPIO registers visible only when device 09.
// - Direction F0h, reset FFh, one means input.
// - Data F1h, reset 00h, outputs read back.
// - Input bits read pin, writes ignored.
// - Inversion F2h, one inverts both directions.
// - Inversion zero passes value unchanged.
module icg_gpio_port
  import icg_pkg::*;
#(
  parameter int          WIDTH   = 8,
  parameter logic [7:0]  GPIO_LDN = ICG_GPIO_LDN
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_rvalid,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    icg_mode_e        mode;
    logic [7:0]       index;
    logic [7:0]       ldn;
    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] dat;
    logic [WIDTH-1:0] inv;
    logic [7:0]       rdata;
    logic             rvalid;
    logic [WIDTH-1:0] pout;
    logic [WIDTH-1:0] poe;
  } icg_state_s;

  icg_state_s st_r;
  icg_state_s st_nxt;

  // The value software sees in the data register: outputs echo the latch,
  // inputs show the (optionally inverted) live pin level.
  function automatic logic [WIDTH-1:0] data_view(input logic [WIDTH-1:0] dir,
                                                 input logic [WIDTH-1:0] dat,
                                                 input logic [WIDTH-1:0] inv,
                                                 input logic [WIDTH-1:0] pin);
    data_view = (dir & (pin ^ inv)) | (~dir & dat);
  endfunction

  logic idx_wr;
  logic dat_wr;
  logic dat_rd;
  logic gpio_sel;
  assign idx_wr   = io_wr && (io_addr == ICG_INDEX_PORT_ADDR);
  assign dat_wr   = io_wr && (io_addr == ICG_DATA_PORT_ADDR);
  assign dat_rd   = io_rd && (io_addr == ICG_DATA_PORT_ADDR);
  assign gpio_sel = (st_r.ldn == GPIO_LDN);

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    logic [7:0] rd;
    rd     = ICG_IDLE_READ;
    st_nxt = st_r;
    st_nxt.rvalid = io_rd;
    if (idx_wr) begin
      unique case (st_r.mode)
        ICG_LOCKED: begin
          if (io_wdata == ICG_KEY_ENTER) st_nxt.mode = ICG_KEY_HALF;
        end
        ICG_KEY_HALF: begin
          // Any other index write breaks the key and starts over.
          st_nxt.mode = (io_wdata == ICG_KEY_ENTER) ? ICG_UNLOCKED : ICG_LOCKED;
        end
        ICG_UNLOCKED: begin
          // Once unlocked, a further enter key is taken as a plain index value.
          if (io_wdata == ICG_KEY_EXIT) st_nxt.mode = ICG_LOCKED;
          else st_nxt.index = io_wdata;
        end
      endcase
    end
    if (dat_wr && st_r.mode == ICG_UNLOCKED) begin
      if (st_r.index == ICG_IDX_LDN) st_nxt.ldn = io_wdata;
      else if (gpio_sel) begin
        unique case (st_r.index)
          ICG_IDX_DIRECTION: st_nxt.dir = io_wdata[WIDTH-1:0];
          ICG_IDX_PIN_DATA:
            st_nxt.dat = (st_r.dat & st_r.dir) | (io_wdata[WIDTH-1:0] & ~st_r.dir);
          ICG_IDX_INVERT:    st_nxt.inv = io_wdata[WIDTH-1:0];
          default: ;
        endcase
      end
    end
    // Refused and unknown reads all return the idle value, as an undecoded bus would.
    if (dat_rd && st_r.mode == ICG_UNLOCKED) begin
      if (st_r.index == ICG_IDX_LDN) rd = st_r.ldn;
      else if (gpio_sel) begin
        unique case (st_r.index)
          ICG_IDX_DIRECTION: rd = 8'(st_r.dir);
          ICG_IDX_PIN_DATA:  rd = 8'(data_view(st_r.dir, st_r.dat, st_r.inv, pin_in));
          ICG_IDX_INVERT:    rd = 8'(st_r.inv);
          default:           rd = ICG_IDLE_READ;
        endcase
      end
    end
    st_nxt.rdata = io_rd ? rd : st_r.rdata;
    // The pins are fed from the next state, so a register write reaches them on the same edge as the register.
    // The output level follows the data latch even on input pins; only the enable decides
    // what reaches the pad, so a later direction change never glitches the driven level.
    st_nxt.pout  = st_nxt.dat ^ st_nxt.inv;
    st_nxt.poe   = ~st_nxt.dir;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r.mode   <= ICG_LOCKED;
      st_r.index  <= ICG_INDEX_RST;
      st_r.ldn    <= ICG_LDN_RST;
      st_r.dir    <= WIDTH'(ICG_DIRECTION_RST);
      st_r.dat    <= WIDTH'(ICG_PIN_DATA_RST);
      st_r.inv    <= WIDTH'(ICG_INVERT_RST);
      st_r.rdata  <= ICG_IDLE_READ;
      st_r.rvalid <= 1'b0;
      st_r.pout   <= WIDTH'(ICG_PIN_DATA_RST ^ ICG_INVERT_RST);
      st_r.poe    <= ~WIDTH'(ICG_DIRECTION_RST);
    end else begin
      st_r <= st_nxt;
    end
  end

  assign io_rdata  = st_r.rdata;
  assign io_rvalid = st_r.rvalid;
  assign pin_out   = st_r.pout;
  assign pin_oe    = st_r.poe;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  unlock_key_a: assert property (
    $rose(st_r.mode == ICG_UNLOCKED) |->
      $past(st_r.mode) == ICG_KEY_HALF && $past(idx_wr) && $past(io_wdata) == ICG_KEY_ENTER)
    else $error("unlocked without double key write");

  lock_exit_a: assert property (
    st_r.mode == ICG_UNLOCKED && idx_wr && io_wdata == ICG_KEY_EXIT |=>
      st_r.mode == ICG_LOCKED)
    else $error("exit key did not lock");

  index_load_a: assert property (
    st_r.mode == ICG_UNLOCKED && idx_wr && io_wdata != ICG_KEY_EXIT |=>
      st_r.index == $past(io_wdata))
    else $error("index not loaded");

  ldn_latch_a: assert property (
    st_r.mode == ICG_UNLOCKED && dat_wr && st_r.index == ICG_IDX_LDN |=>
      st_r.ldn == $past(io_wdata))
    else $error("device number not latched");

  gpio_hidden_a: assert property (
    !gpio_sel |=> $stable(st_r.dir) && $stable(st_r.inv) && $stable(st_r.dat))
    else $error("gpio register changed while deselected");

  locked_hold_a: assert property (
    st_r.mode != ICG_UNLOCKED |=> $stable(st_r.dir) && $stable(st_r.dat) && $stable(st_r.ldn))
    else $error("register changed while locked");

  input_write_a: assert property (
    dat_wr |=> ((st_r.dat ^ $past(st_r.dat)) & $past(st_r.dir)) == '0)
    else $error("write changed an input bit");

  // The pin checks tie each register write to the pins rather than restating the output logic.
  pin_drive_a: assert property (
    dat_wr && st_r.mode == ICG_UNLOCKED && gpio_sel && st_r.index == ICG_IDX_INVERT |=>
      pin_out == ($past(st_r.dat) ^ $past(io_wdata[WIDTH-1:0])))
    else $error("inversion not applied to pins");

  oe_follow_a: assert property (
    dat_wr && st_r.mode == ICG_UNLOCKED && gpio_sel && st_r.index == ICG_IDX_DIRECTION |=>
      pin_oe == ~$past(io_wdata[WIDTH-1:0]))
    else $error("direction write not applied to pins");

  out_write_a: assert property (
    dat_wr && st_r.mode == ICG_UNLOCKED && gpio_sel && st_r.index == ICG_IDX_PIN_DATA |=>
      ((pin_out ^ st_r.inv) & pin_oe) == ($past(io_wdata[WIDTH-1:0]) & pin_oe))
    else $error("output write not driven");

  input_read_a: assert property (
    dat_rd && st_r.mode == ICG_UNLOCKED && gpio_sel && st_r.index == ICG_IDX_PIN_DATA |=>
      ((io_rdata[WIDTH-1:0] ^ ($past(pin_in) ^ $past(st_r.inv))) & $past(st_r.dir)) == '0)
    else $error("input bit read not taken from pin");

  locked_read_a: assert property (
    dat_rd && st_r.mode != ICG_UNLOCKED |=> io_rdata == ICG_IDLE_READ)
    else $error("locked read did not return idle value");

  rvalid_pulse_a: assert property (io_rvalid == $past(io_rd))
    else $error("read valid pulse misplaced");

  read_answer_a: assert property (
    dat_rd && st_r.mode == ICG_UNLOCKED && gpio_sel && st_r.index == ICG_IDX_DIRECTION |=>
      io_rvalid && io_rdata == 8'($past(st_r.dir)))
    else $error("direction readback wrong");

  unlock_c: cover property (st_r.mode == ICG_KEY_HALF ##[1:20] st_r.mode == ICG_UNLOCKED);
  out_drive_c: cover property (gpio_sel && pin_oe != '0);
  input_read_c: cover property (dat_rd && st_r.index == ICG_IDX_PIN_DATA && st_r.dir != '0);
  key_exit_c: cover property (st_r.mode == ICG_UNLOCKED ##1 st_r.mode == ICG_LOCKED);

endmodule // icg_gpio_port

// *** testbench/icg_host_model.sv ***
module icg_host_model
  import icg_pkg::*;
(
  input  wire logic        sys_clk,
  output logic      [15:0] io_addr,
  output logic             io_wr,
  output logic             io_rd,
  output logic      [7:0]  io_wdata,
  input  wire logic [7:0]  io_rdata,
  input  wire logic        io_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    io_addr  = 16'h0000;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_wdata = 8'h00;
  end
  // Released lines show the inverse so a stale value never looks valid.
  task automatic wr(input logic [15:0] a, input logic [7:0] x);
    @(posedge sys_clk);
    io_addr  <= a;
    io_wdata <= x;
    io_wr    <= 1'b1;
    @(posedge sys_clk);
    io_wr    <= 1'b0;
    io_addr  <= ~a;
    io_wdata <= ~x;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] x, output logic v);
    @(posedge sys_clk);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge sys_clk);
    io_rd   <= 1'b0;
    io_addr <= ~a;
    @(posedge sys_clk);
    x = io_rdata;
    v = io_rvalid;
  endtask
endmodule // icg_host_model

// *** testbench/test_indexed_config_gpio_port.sv ***
module test_indexed_config_gpio_port
  import icg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk, rst, io_wr, io_rd, io_rvalid, v;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, pin_in, pin_out, pin_oe, d;
  int          n_mismatch, n_compared, cyc;
  icg_gpio_port i_dut (.sys_clk(sys_clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  icg_host_model i_host (.sys_clk(sys_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid));
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic cw(input logic [7:0] i, input logic [7:0] x);
    i_host.wr(ICG_INDEX_PORT_ADDR, i);
    i_host.wr(ICG_DATA_PORT_ADDR, x);
  endtask
  task automatic cr(input logic [7:0] i, input logic [7:0] e, input string s);
    i_host.wr(ICG_INDEX_PORT_ADDR, i);
    i_host.rd(ICG_DATA_PORT_ADDR, d, v);
    chk(s, e, d);
    chk("io_rvalid", 8'h01, {7'h00, v});
  endtask
  // Pin registers update on the same edge as the register write; two falling edges leave margin.
  task automatic pins(input logic [7:0] eo, input logic [7:0] ep);
    repeat (2) @(negedge sys_clk);
    chk("pin_oe", eo, pin_oe);
    chk("pin_out", ep, pin_out);
  endtask
  task automatic test_done;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      test_done();
    end
  end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rst    = 1'b1;
    pin_in = 8'h5a;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    pins(8'h00, 8'h00);
    cw(ICG_IDX_DIRECTION, 8'h00);
    i_host.rd(ICG_DATA_PORT_ADDR, d, v);
    chk("locked read", 8'hff, d);
    i_host.wr(ICG_INDEX_PORT_ADDR, ICG_KEY_ENTER);
    i_host.wr(ICG_INDEX_PORT_ADDR, 8'h07);
    i_host.wr(ICG_INDEX_PORT_ADDR, ICG_KEY_ENTER);
    cr(ICG_IDX_LDN, 8'hff, "broken key");
    i_host.wr(ICG_INDEX_PORT_ADDR, ICG_KEY_ENTER);
    i_host.wr(ICG_INDEX_PORT_ADDR, ICG_KEY_ENTER);
    cw(ICG_IDX_LDN, ICG_GPIO_LDN);
    cr(ICG_IDX_LDN, 8'h09, "device select");
    cr(ICG_IDX_DIRECTION, 8'hff, "direction reset");
    cr(ICG_IDX_PIN_DATA, 8'h5a, "input read");
    cw(ICG_IDX_PIN_DATA, 8'hff);
    cr(ICG_IDX_PIN_DATA, 8'h5a, "input write");
    cw(ICG_IDX_DIRECTION, 8'h0f);
    cw(ICG_IDX_PIN_DATA, 8'ha5);
    pins(8'hf0, 8'ha0);
    cr(ICG_IDX_PIN_DATA, 8'haa, "mixed read");
    cw(ICG_IDX_INVERT, 8'hff);
    pins(8'hf0, 8'h5f);
    cr(ICG_IDX_PIN_DATA, 8'ha5, "inverted read");
    cw(ICG_IDX_LDN, 8'h07);
    cr(ICG_IDX_DIRECTION, 8'hff, "other device");
    cw(ICG_IDX_DIRECTION, 8'h00);
    cw(ICG_IDX_LDN, ICG_GPIO_LDN);
    cr(ICG_IDX_DIRECTION, 8'h0f, "device back");
    cr(8'hf3, 8'hff, "unknown index");
    i_host.wr(ICG_INDEX_PORT_ADDR, ICG_KEY_EXIT);
    cw(ICG_IDX_DIRECTION, 8'h00);
    pins(8'hf0, 8'h5f);
    cr(ICG_IDX_DIRECTION, 8'hff, "after exit");
    i_host.rd(16'h0030, d, v);
    chk("unmapped", 8'hff, d);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    pins(8'h00, 8'h00);
    i_host.wr(ICG_INDEX_PORT_ADDR, ICG_KEY_ENTER);
    i_host.wr(ICG_INDEX_PORT_ADDR, ICG_KEY_ENTER);
    cr(ICG_IDX_LDN, 8'h00, "device after reset");
    test_done();
  end
endmodule // test_indexed_config_gpio_port
